//--- design/frame_timer.sv
`timescale 1ns/10ps
module frame_timer
    import hc_regs_pkg::*;
#(
    parameter int DELAY_CYCLES = SOF_DELAY_CYCLES_DEF,
    parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
)
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // control
    input wire logic start_in,
    input wire logic run_in,
    // frame events
    output logic sof_out,
    output logic eof_out
);

    localparam logic [TIMER_W-1:0] DELAY_LOAD = TIMER_W'(DELAY_CYCLES - 1);
    localparam logic [TIMER_W-1:0] FRAME_LOAD = TIMER_W'(FRAME_CYCLES - 1);
    localparam logic [TIMER_W-1:0] EOF_COUNT = 20'h00001;

    logic [TIMER_W-1:0] count_r;
    logic framing_r;

    // counter reloads on every start, so a brief stay outside
    // operational restarts the full delay before the first frame start
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            count_r <= '0;
            framing_r <= 1'b0;
            sof_out <= 1'b0;
            eof_out <= 1'b0;
        end
        else if (start_in)
        begin
            count_r <= DELAY_LOAD;
            framing_r <= 1'b0;
            sof_out <= 1'b0;
            eof_out <= 1'b0;
        end
        else if (!run_in)
        begin
            framing_r <= 1'b0;
            sof_out <= 1'b0;
            eof_out <= 1'b0;
        end
        else
        begin
            sof_out <= (count_r == '0);
            eof_out <= framing_r && (count_r == EOF_COUNT);
            if (count_r == '0)
            begin
                count_r <= FRAME_LOAD;
                framing_r <= 1'b1;
            end
            else
            begin
                count_r <= count_r - EOF_COUNT;
            end
        end
    end

endmodule : frame_timer

//--- design/hc_control_command_regs.sv
`timescale 1ns/10ps
// What this block does
// - state field codes: bus reset 00, resume 01, operational 10, suspend 11.
// - entering operational from another state starts frame starts after one millisecond.
// - each frame start raises the frame-start flag for interrupt status bit 2.
// - hardware changes state only in suspend, moving to resume on downstream resume.
// - software reset gives suspend; hardware reset gives bus reset, hub and port reset.
// - bulk enable acts from next frame; clearing stops bulk after next frame start.
// - control enable acts from next frame; clearing stops control after next start.
// - isochronous descriptor found: continue if iso enabled, else halt periodic list.
// - setting iso enable takes effect next frame, never the current one.
// - periodic enable acts from next frame; clearing stops periodic after next start.
// - ratio field 00..11 serves one to four control descriptors per bulk one.
// - ratio compared with a served-control count kept across frame boundaries.
// - command register writes set bits on ones, ignore zeros; reads return all.
// - bits 17:16 count frames where periodic list missed end of frame.
// - on overrun, increment the count and raise the overrun flag, status bit 0.
// - overrun count starts at 00, wraps after 11, counts even if flag set.
module hc_control_command_regs
    import hc_regs_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYCLES_DEF,
    parameter int SOF_DELAY_CYCLES = SOF_DELAY_CYCLES_DEF
)
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // register port
    input wire logic [hc_regs_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [hc_regs_pkg::DATA_W-1:0] reg_wdata_in,
    output logic [hc_regs_pkg::DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // events from port and list engines
    input wire logic resume_detect_in,
    input wire logic periodic_done_in,
    input wire logic iso_ed_found_in,
    input wire logic ctrl_served_in,
    input wire logic bulk_served_in,
    input wire logic ctrl_filled_clear_in,
    input wire logic bulk_filled_clear_in,
    input wire logic ownership_done_in,
    // frame and list control
    output logic sof_out,
    output hc_regs_pkg::list_enable_t lists_out,
    output logic periodic_halt_out,
    output logic pick_control_out,
    // status events and port reset
    output logic frame_start_flag_out,
    output logic sched_overrun_out,
    output logic soft_reset_out,
    output logic port_reset_out
);

    import hc_regs_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    host_control_t ctrl_r;
    logic [CMD_FLAGS_W-1:0] cmd_flags_r;
    logic [SOC_W-1:0] soc_r;
    logic hcr_pending_r;
    logic periodic_done_r;
    logic start_pulse;
    logic sof;
    logic eof;
    logic overrun;
    logic wr_ctrl;
    logic wr_cmd;
    logic soft_reset;
    host_control_t wr_value;
    functional_state_t state_nxt;
    logic [CMD_FLAGS_W-1:0] hw_clear;
    logic [CMD_FLAGS_W-1:0] cmd_set;

    assign wr_ctrl = reg_wr_in && (reg_addr_in == CONTROL_OFFSET);
    assign wr_cmd = reg_wr_in && (reg_addr_in == COMMAND_OFFSET);
    assign wr_value = host_control_t'(reg_wdata_in[CTRL_W-1:0]);
    // reset request is acted on one cycle after it is written
    assign soft_reset = hcr_pending_r;
    assign cmd_set = wr_cmd ? reg_wdata_in[CMD_FLAGS_W-1:0] : '0;
    assign hw_clear[CMD_HCR_BIT] = 1'b0;
    assign hw_clear[CMD_CLF_BIT] = ctrl_filled_clear_in;
    assign hw_clear[CMD_BLF_BIT] = bulk_filled_clear_in;
    assign hw_clear[CMD_OCR_BIT] = ownership_done_in;

    // ----------------------------------------------------------------
    // functional state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = ctrl_r.functional_state;
        if (soft_reset)
        begin
            state_nxt = bus_suspend_state;
        end
        else if (wr_ctrl)
        begin
            state_nxt = wr_value.functional_state;
        end
        else if (ctrl_r.functional_state == bus_suspend_state && resume_detect_in)
        begin
            state_nxt = bus_resume_state;
        end
    end

    // entry into operational from any other state arms the frame timer
    assign start_pulse = (state_nxt == bus_operational_state)
                         && (ctrl_r.functional_state != bus_operational_state);

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ctrl_r <= CONTROL_RESET;
        end
        else if (soft_reset)
        begin
            // wakeup-connected and routing survive a software reset
            ctrl_r <= CONTROL_RESET;
            ctrl_r.wakeup_connected <= ctrl_r.wakeup_connected;
            ctrl_r.interrupt_routing <= ctrl_r.interrupt_routing;
            ctrl_r.functional_state <= state_nxt;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= wr_value;
            end
            ctrl_r.functional_state <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // command and status register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cmd_flags_r <= '0;
            hcr_pending_r <= 1'b0;
        end
        else
        begin
            hcr_pending_r <= wr_cmd && reg_wdata_in[CMD_HCR_BIT];
            if (soft_reset)
            begin
                cmd_flags_r <= '0;
            end
            else
            begin
                // a one written in the same cycle as a hardware clear wins,
                // a zero written leaves that hardware clear in force
                cmd_flags_r <= (cmd_flags_r & ~hw_clear) | cmd_set;
            end
        end
    end

    // ----------------------------------------------------------------
    // scheduling overrun
    // ----------------------------------------------------------------
    assign overrun = eof && lists_out.periodic && !periodic_done_r;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            periodic_done_r <= 1'b0;
        end
        else if (periodic_done_in)
        begin
            periodic_done_r <= 1'b1;
        end
        else if (sof)
        begin
            periodic_done_r <= 1'b0;
        end
    end

    // counter is not writable by software, so the count stays honest
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            soc_r <= '0;
        end
        else if (soft_reset)
        begin
            soc_r <= '0;
        end
        else if (overrun)
        begin
            soc_r <= soc_r + SOC_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // frame timing and per-frame list enables
    // ----------------------------------------------------------------
    frame_timer #(
        .DELAY_CYCLES(SOF_DELAY_CYCLES),
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_frame_timer (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .start_in(start_pulse),
        .run_in(ctrl_r.functional_state == bus_operational_state),
        .sof_out(sof),
        .eof_out(eof)
    );

    // enables are sampled only at frame start, so a change never
    // reaches the frame in progress
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            lists_out <= LISTS_OFF;
        end
        else if (ctrl_r.functional_state != bus_operational_state)
        begin
            lists_out <= LISTS_OFF;
        end
        else if (sof)
        begin
            lists_out.periodic <= ctrl_r.periodic_list_enable;
            lists_out.iso <= ctrl_r.iso_enable;
            lists_out.ctrl <= ctrl_r.ctrl_list_enable;
            lists_out.bulk <= ctrl_r.bulk_list_enable;
        end
    end

    // ----------------------------------------------------------------
    // event outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sof_out <= 1'b0;
            frame_start_flag_out <= 1'b0;
            sched_overrun_out <= 1'b0;
            periodic_halt_out <= 1'b0;
            soft_reset_out <= 1'b0;
        end
        else
        begin
            sof_out <= sof;
            frame_start_flag_out <= sof;
            sched_overrun_out <= overrun;
            periodic_halt_out <= iso_ed_found_in && !lists_out.iso;
            soft_reset_out <= soft_reset;
        end
    end

    // bus reset state drives reset onto ports and the root hub
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            port_reset_out <= 1'b1;
        end
        else
        begin
            port_reset_out <= (state_nxt == bus_reset_state);
        end
    end

    ratio_tracker u_ratio_tracker (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .ratio_in(ctrl_r.ctrl_bulk_ratio),
        .ctrl_served_in(ctrl_served_in),
        .bulk_served_in(bulk_served_in),
        .pick_control_out(pick_control_out)
    );

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            reg_rdata_out <= READ_ZERO;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            reg_rdata_out <= READ_ZERO;
            if (reg_rd_in && reg_addr_in == CONTROL_OFFSET)
            begin
                reg_rdata_out <= DATA_W'(ctrl_r);
            end
            else if (reg_rd_in && reg_addr_in == COMMAND_OFFSET)
            begin
                reg_rdata_out <= DATA_W'({soc_r, {(SOC_LSB - CMD_FLAGS_W){1'b0}}, cmd_flags_r});
            end
        end
    end

endmodule : hc_control_command_regs

//--- design/ratio_tracker.sv
`timescale 1ns/10ps
module ratio_tracker
    import hc_regs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // setting and service events
    input wire logic [RATIO_W-1:0] ratio_in,
    input wire logic ctrl_served_in,
    input wire logic bulk_served_in,
    // decision
    output logic pick_control_out
);

    logic [CTRL_COUNT_W-1:0] served_r;
    logic [CTRL_COUNT_W-1:0] limit;

    assign limit = CTRL_COUNT_W'(ratio_in) + CTRL_COUNT_W'(1);

    // count is never touched by frame boundaries, only by service events
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            served_r <= '0;
        end
        else if (bulk_served_in)
        begin
            served_r <= '0;
        end
        else if (ctrl_served_in && served_r < limit)
        begin
            served_r <= served_r + CTRL_COUNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pick_control_out <= 1'b1;
        end
        else
        begin
            pick_control_out <= (served_r < limit);
        end
    end

endmodule : ratio_tracker

//--- shared/hc_regs_pkg.sv
package hc_regs_pkg;

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] COMMAND_OFFSET = 8'h08;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int CTRL_W = 11;
    localparam int RATIO_W = 2;
    localparam int SOC_W = 2;
    localparam int SOC_LSB = 16;
    localparam int CMD_HCR_BIT = 0;
    localparam int CMD_CLF_BIT = 1;
    localparam int CMD_BLF_BIT = 2;
    localparam int CMD_OCR_BIT = 3;
    localparam int CMD_FLAGS_W = 4;
    localparam int CTRL_COUNT_W = 3;

    typedef enum logic [1:0] {
        bus_reset_state = 2'h0,
        bus_resume_state = 2'h1,
        bus_operational_state = 2'h2,
        bus_suspend_state = 2'h3
    } functional_state_t;

    // packed in register bit order, bit 10 down to bit 0
    typedef struct packed {
        logic remote_wake_enable;
        logic wakeup_connected;
        logic interrupt_routing;
        functional_state_t functional_state;
        logic bulk_list_enable;
        logic ctrl_list_enable;
        logic iso_enable;
        logic periodic_list_enable;
        logic [RATIO_W-1:0] ctrl_bulk_ratio;
    } host_control_t;

    localparam host_control_t CONTROL_RESET = 11'h000;

    typedef struct packed {
        logic periodic;
        logic iso;
        logic ctrl;
        logic bulk;
    } list_enable_t;

    localparam list_enable_t LISTS_OFF = 4'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 100;
    localparam int FRAME_TIME_US = 1000;
    localparam int SOF_DELAY_US = 1000;
    localparam int FRAME_CYCLES_DEF = FRAME_TIME_US * CLK_FREQ_MHZ;
    localparam int SOF_DELAY_CYCLES_DEF = SOF_DELAY_US * CLK_FREQ_MHZ;
    localparam int TIMER_W = 20;

endpackage : hc_regs_pkg

//--- sim/hc_regs_assertions.sv
`timescale 1ns/10ps
module hc_regs_checker
    import hc_regs_pkg::*;
#(
    parameter int FRAME_CYCLES = 20,
    parameter int SOF_DELAY_CYCLES = 10
)
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // register port
    input wire logic [hc_regs_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [hc_regs_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic [hc_regs_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // frame and list side
    input wire logic iso_ed_found_in,
    input wire logic sof_out,
    input wire hc_regs_pkg::list_enable_t lists_out,
    input wire logic periodic_halt_out,
    input wire logic frame_start_flag_out,
    input wire logic port_reset_out
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // long counts must be shortened by parameter before these delays are legal
    localparam int SOF_AT = SOF_DELAY_CYCLES + 2;
    localparam int QUIET = SOF_DELAY_CYCLES + 1;
    logic [31:0] gap_r;
    logic armed_r;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
        if (!resetn_in)
            gap_r <= 32'h0;
        else if (sof_out)
            gap_r <= 32'h1;
        else
            gap_r <= gap_r + 32'h1;

    // any write may move the state, so only untouched frames are timed
    always_ff @(posedge clk_sys_in or negedge resetn_in)
        if (!resetn_in)
            armed_r <= 1'b0;
        else if (reg_wr_in)
            armed_r <= 1'b0;
        else if (sof_out)
            armed_r <= 1'b1;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    sequence ctrl_wr;
        reg_wr_in && reg_addr_in == CONTROL_OFFSET;
    endsequence
    sequence enter_op;
        ctrl_wr ##0 (reg_wdata_in[7:6] == 2'h2 && port_reset_out);
    endsequence

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_read_valid: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_idle_quiet: assert property (!reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == READ_ZERO)
        else $error("read data without read");
    a_unmapped_zero: assert property (reg_rd_in && reg_addr_in != CONTROL_OFFSET
        && reg_addr_in != COMMAND_OFFSET |=> reg_rdata_out == READ_ZERO)
        else $error("unmapped read not zero");
    a_reset_state_pin: assert property (ctrl_wr ##0 reg_wdata_in[7:6] == 2'h0 |=> port_reset_out)
        else $error("port reset missing in bus reset state");
    a_run_state_pin: assert property (ctrl_wr ##0 reg_wdata_in[7:6] != 2'h0 |=> !port_reset_out)
        else $error("port reset outside bus reset state");
    a_sof_quiet: assert property (enter_op |-> not (##[1:QUIET] sof_out))
        else $error("frame start too early");
    a_sof_delay: assert property (enter_op |-> ##SOF_AT sof_out)
        else $error("frame start not at delay");
    a_flag_with_sof: assert property (frame_start_flag_out == sof_out)
        else $error("frame start flag apart from frame start");
    a_frame_period: assert property (sof_out && armed_r |-> gap_r == FRAME_CYCLES)
        else $error("frame period wrong");
    a_lists_at_frame: assert property ($changed(lists_out)
        |-> sof_out || $past(sof_out) || lists_out == LISTS_OFF)
        else $error("list enables changed inside a frame");
    a_lists_when_idle: assert property (port_reset_out && $past(port_reset_out)
        |-> lists_out == LISTS_OFF)
        else $error("lists enabled while not operational");
    a_halt_iso: assert property (iso_ed_found_in && !lists_out.iso |=> periodic_halt_out)
        else $error("periodic list not halted");
    a_halt_cause: assert property (!(iso_ed_found_in && !lists_out.iso) |=> !periodic_halt_out)
        else $error("periodic halt without cause");
endmodule : hc_regs_checker

bind hc_control_command_regs hc_regs_checker #(
    .FRAME_CYCLES(FRAME_CYCLES), .SOF_DELAY_CYCLES(SOF_DELAY_CYCLES)
) hc_regs_checker_inst (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .iso_ed_found_in(iso_ed_found_in), .sof_out(sof_out), .lists_out(lists_out),
    .periodic_halt_out(periodic_halt_out), .frame_start_flag_out(frame_start_flag_out),
    .port_reset_out(port_reset_out)
);

//--- sim/test_hc_control_command_regs.sv
`timescale 1ns/10ps
module test_hc_control_command_regs;
    import hc_regs_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } row_t;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic [31:0] reg_rdata_out;
    logic reg_rvalid_out, sof_out, periodic_halt_out, pick_control_out;
    logic frame_start_flag_out, sched_overrun_out, soft_reset_out, port_reset_out;
    list_enable_t lists_out;
    // event inputs: resume, done, iso, ctrl, bulk, ctrl clr, bulk clr, owner
    logic [7:0] ev = 8'h00;
    int fail_count = 0;
    int n_tests = 0;
    int ov_n = 0;
    int sr_n = 0;
    int r, k;
    row_t rows [8] = '{
        '{8'h04, 32'hFFFF_FFFF, 32'h0000_07FF}, '{8'h04, 32'h0000_0655, 32'h0000_0655},
        '{8'h04, 32'h0000_0000, 32'h0000_0000}, '{8'h0C, 32'h1234_5678, 32'h0000_0000},
        '{8'h08, 32'h0000_0006, 32'h0000_0006}, '{8'h08, 32'h0000_0008, 32'h0000_000E},
        '{8'h08, 32'h0000_0000, 32'h0000_000E}, '{8'h08, 32'hFFFF_FFF0, 32'h0000_000E}};

    always #5 clk_sys_in = ~clk_sys_in;

    always @(posedge clk_sys_in)
    begin
        if (sched_overrun_out === 1'b1)
            ov_n++;
        if (soft_reset_out === 1'b1)
            sr_n++;
    end

    hc_control_command_regs #(.FRAME_CYCLES(20), .SOF_DELAY_CYCLES(10)) hc_control_command_regs_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .resume_detect_in(ev[0]), .periodic_done_in(ev[1]), .iso_ed_found_in(ev[2]),
        .ctrl_served_in(ev[3]), .bulk_served_in(ev[4]), .ctrl_filled_clear_in(ev[5]),
        .bulk_filled_clear_in(ev[6]), .ownership_done_in(ev[7]), .sof_out(sof_out),
        .lists_out(lists_out), .periodic_halt_out(periodic_halt_out),
        .pick_control_out(pick_control_out), .frame_start_flag_out(frame_start_flag_out),
        .sched_overrun_out(sched_overrun_out), .soft_reset_out(soft_reset_out),
        .port_reset_out(port_reset_out));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // inputs always move 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cyc(1);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        cyc(1);
        reg_wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cyc(1);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        cyc(1);
        reg_rd_in = 1'b0;
        chk_bit(reg_rvalid_out, 1'b1);
        chk_word(reg_rdata_out, exp);
    endtask : rd

    task automatic pulse(input int i);
        cyc(1);
        ev[i] = 1'b1;
        cyc(1);
        ev[i] = 1'b0;
    endtask : pulse

    task automatic wsof;
        int n;
        n = 0;
        do
        begin
            cyc(1);
            n++;
        end
        while (sof_out !== 1'b1 && n < 100);
        chk_bit(sof_out, 1'b1);
    endtask : wsof

    task automatic close_out;
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    initial
    begin
        #50000;
        fail_count++;
        close_out();
    end

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_sys_in);
        #1;
        chk_bit(port_reset_out, 1'b1);
        chk_bit(pick_control_out, 1'b1);
        resetn_in = 1'b1;
        rd(8'h04, 32'h0000_0000);
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rexp);
        end
        pulse(5);
        rd(8'h08, 32'h0000_000C);
        pulse(6);
        rd(8'h08, 32'h0000_0008);
        pulse(7);
        rd(8'h08, 32'h0000_0000);
        // software set and hardware clear in the same cycle: set must win
        cyc(1);
        ev[5] = 1'b1;
        reg_wr_in = 1'b1;
        reg_addr_in = 8'h08;
        reg_wdata_in = 32'h0000_0002;
        cyc(1);
        ev[5] = 1'b0;
        reg_wr_in = 1'b0;
        rd(8'h08, 32'h0000_0002);
        for (r = 0; r < 4; r++)
        begin
            wr(8'h04, 32'(r));
            pulse(4);
            cyc(1);
            for (k = 0; k <= r; k++)
            begin
                chk_bit(pick_control_out, 1'b1);
                pulse(3);
                cyc(1);
            end
            chk_bit(pick_control_out, 1'b0);
        end
        wr(8'h04, 32'h0000_033F);
        wr(8'h08, 32'h0000_0001);
        cyc(2);
        chk_bit(pick_control_out, 1'b0);
        rd(8'h04, 32'h0000_03C0);
        rd(8'h08, 32'h0000_0000);
        chk_word(32'(sr_n), 32'h0000_0001);
        pulse(0);
        rd(8'h04, 32'h0000_0340);
        wr(8'h04, 32'h0000_0000);
        pulse(0);
        rd(8'h04, 32'h0000_0000);
        chk_bit(port_reset_out, 1'b1);
        wr(8'h04, 32'h0000_0084);
        cyc(10);
        chk_bit(sof_out, 1'b0);
        cyc(1);
        chk_bit(sof_out, 1'b1);
        chk_bit(frame_start_flag_out, 1'b1);
        cyc(2);
        chk_word(32'(lists_out), 32'h0000_0008);
        wr(8'h04, 32'h0000_00BC);
        pulse(2);
        chk_bit(periodic_halt_out, 1'b1);
        chk_word(32'(lists_out), 32'h0000_0008);
        wsof();
        cyc(2);
        chk_word(32'(lists_out), 32'h0000_000F);
        pulse(1);
        pulse(2);
        chk_bit(periodic_halt_out, 1'b0);
        wr(8'h04, 32'h0000_0098);
        wsof();
        cyc(2);
        chk_word(32'(lists_out), 32'h0000_0006);
        rd(8'h08, 32'h0001_0000);
        wr(8'h04, 32'h0000_0084);
        repeat (4) wsof();
        cyc(3);
        rd(8'h08, 32'h0000_0000);
        chk_word(32'(ov_n), 32'h0000_0004);
        wr(8'h04, 32'h0000_0684);
        cyc(3);
        resetn_in = 1'b0;
        cyc(3);
        chk_bit(port_reset_out, 1'b1);
        chk_bit(pick_control_out, 1'b1);
        chk_word(32'(lists_out), 32'h0000_0000);
        resetn_in = 1'b1;
        rd(8'h04, 32'h0000_0000);
        close_out();
    end
endmodule : test_hc_control_command_regs
